// ===== rtl/usb_bus_control.sv
// USB bus control: address/enable, manual transmit, frame number, activity and sleep
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
module usb_bus_control
   import usb_ctrl_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic dp_in,
   input wire logic dm_in,
   output logic dp_out,
   output logic dm_out,
   output logic line_oe,
   input wire line_drive_type sie_drive,
   input wire sof_type sof_in,
   input wire logic bus_reset,
   input wire logic [6:0] token_addr,
   output logic addr_match,
   output logic usb_enable,
   output logic regulator_mode,
   output logic osc_lock_enable,
   output logic asleep,
   output logic wake_irq,
   output logic nonretained_clear
);
   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [1:0] dp_sync_q;
   logic [1:0] dm_sync_q;
   logic dp_last_q;
   logic dm_last_q;
   logic dp_s;
   logic dm_s;
   logic activity_evt;

   // Flops start at the idle J level so leaving reset makes no false edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dp_sync_q <= {2{DP_IDLE}};
         dm_sync_q <= {2{DM_IDLE}};
         dp_last_q <= DP_IDLE;
         dm_last_q <= DM_IDLE;
      end else begin
         dp_sync_q <= {dp_sync_q[0], dp_in};
         dm_sync_q <= {dm_sync_q[0], dm_in};
         dp_last_q <= dp_sync_q[1];
         dm_last_q <= dm_sync_q[1];
      end
   end

   assign dp_s = dp_sync_q[1];
   assign dm_s = dm_sync_q[1];
   // Any edge on either line counts as bus activity
   assign activity_evt = (dp_s != dp_last_q) || (dm_s != dm_last_q);

   // ------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------
   logic [7:0] idx;
   logic mapped;
   logic wr_en;
   logic rd_en;
   logic wr_lane0;

   assign idx = paddr[ADDR_LSB +: 8];
   assign mapped = (paddr[1:0] == 2'h0) && (paddr[31:ADDR_LSB + 8] == '0) &&
      (idx == IDX_FRAME_LO || idx == IDX_FRAME_HI || idx == IDX_ADDR_EN ||
       idx == IDX_MANUAL_TX || idx == IDX_BUS_CTRL || idx == IDX_SLEEP_CTRL);
   assign wr_en = psel && penable && pwrite && mapped;
   assign rd_en = psel && penable && !pwrite;
   // Registers are one byte wide, so only lane 0 carries a write
   assign wr_lane0 = wr_en && pstrb[0];
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // ------------------------------------------------------------
   // Sleep control
   // ------------------------------------------------------------
   sleep_state_type state_q;
   sleep_mode_type mode_q;
   logic dp_low_q;
   logic sleep_req;

   assign sleep_req = wr_lane0 && (idx == IDX_SLEEP_CTRL) && pwdata[SLEEP_REQ_BIT];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_AWAKE;
         mode_q <= SLEEP_RETAIN;
         dp_low_q <= 1'b0;
      end else begin
         unique case (state_q)
            ST_AWAKE: begin
               if (sleep_req) begin
                  state_q <= ST_ASLEEP;
                  mode_q <= sleep_mode_type'(pwdata[1:0]);
                  dp_low_q <= !dp_s;
               end
            end
            ST_ASLEEP: begin
               if (activity_evt || dp_low_q) begin
                  state_q <= ST_WAKING;
               end
            end
            ST_WAKING: begin
               state_q <= ST_AWAKE;
               dp_low_q <= 1'b0;
            end
            default: begin
               state_q <= ST_AWAKE;
            end
         endcase
      end
   end

   assign asleep = (state_q == ST_ASLEEP);
   // Asserts only while asleep, so it may be left enabled at all times
   assign wake_irq = asleep && (activity_evt || dp_low_q);
   // Retention mode keeps everything; the other modes lose the endpoint side
   assign nonretained_clear = (state_q == ST_WAKING) && (mode_q != SLEEP_RETAIN);

   // ------------------------------------------------------------
   // Address and enable register
   // ------------------------------------------------------------
   logic [7:0] addr_en_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_en_q <= ADDR_EN_RESET;
      end else if (bus_reset) begin
         addr_en_q <= ADDR_EN_RESET;
      end else if (wr_lane0 && idx == IDX_ADDR_EN) begin
         addr_en_q <= pwdata[7:0];
      end
   end

   assign usb_enable = addr_en_q[ENABLE_BIT];
   assign addr_match = usb_enable && (token_addr == addr_en_q[ADDR_MSB:0]);

   // ------------------------------------------------------------
   // Bus control: regulator, oscillator lock, activity flag
   // ------------------------------------------------------------
   logic [1:0] bus_ctrl_q;
   logic activity_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_ctrl_q <= BUS_CTRL_RESET;
      end else if (wr_lane0 && idx == IDX_BUS_CTRL) begin
         bus_ctrl_q <= pwdata[1:0];
      end
   end

   // Write one clears; a new edge in the same cycle wins over the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         activity_q <= 1'b0;
      end else if (activity_evt) begin
         activity_q <= 1'b1;
      end else if (wr_lane0 && idx == IDX_BUS_CTRL && pwdata[ACTIVITY_BIT]) begin
         activity_q <= 1'b0;
      end
   end

   assign regulator_mode = bus_ctrl_q[REG_MODE_BIT];
   assign osc_lock_enable = bus_ctrl_q[OSC_LOCK_BIT];

   // ------------------------------------------------------------
   // Frame number
   // ------------------------------------------------------------
   logic [FRAME_W-1:0] frame_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_q <= FRAME_RESET;
      end else if (nonretained_clear) begin
         frame_q <= FRAME_RESET;
      end else if (sof_in.valid && usb_enable && state_q == ST_AWAKE) begin
         frame_q <= sof_in.number;
      end
   end

   // ------------------------------------------------------------
   // Manual transmit and pin drive
   // ------------------------------------------------------------
   logic [2:0] manual_q;
   logic tx_en;
   logic tx_se0;
   logic tx_ls;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         manual_q <= MANUAL_TX_RESET;
      end else if (wr_lane0 && idx == IDX_MANUAL_TX) begin
         manual_q <= pwdata[TX_EN_BIT:TX_LS_BIT];
      end
   end

   assign tx_en = manual_q[2];
   assign tx_se0 = manual_q[1];
   assign tx_ls = manual_q[0];

   // Pins are registered; the SIE path gains one cycle of latency for clean outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dp_out <= 1'b0;
         dm_out <= 1'b0;
         line_oe <= 1'b0;
      end else if (tx_en) begin
         line_oe <= 1'b1;
         dp_out <= !tx_se0 && tx_ls;
         dm_out <= !tx_se0 && !tx_ls;
      end else begin
         line_oe <= sie_drive.oe && usb_enable;
         dp_out <= sie_drive.dp;
         dm_out <= sie_drive.dm;
      end
   end

   // ------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------
   logic rx_diff;

   assign rx_diff = dp_s && !dm_s;

   always_comb begin
      prdata = 32'h0000_0000;
      if (rd_en) begin
         unique case (idx)
            IDX_FRAME_LO: prdata[7:0] = frame_q[FRAME_LO_W-1:0];
            IDX_FRAME_HI: prdata[2:0] = frame_q[FRAME_W-1:FRAME_LO_W];
            IDX_ADDR_EN: prdata[7:0] = addr_en_q;
            IDX_MANUAL_TX: prdata[7:0] = {manual_q, 4'h0, rx_diff};
            IDX_BUS_CTRL: prdata[2:0] = {activity_q, bus_ctrl_q};
            IDX_SLEEP_CTRL: prdata[7:0] = {asleep, 5'h00, mode_q};
            default: prdata = 32'h0000_0000;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   addr_clear_a: assert property (bus_reset |=> addr_en_q == 8'h00)
      else $error("Bus reset did not clear address register");
   wake_asleep_a: assert property (wake_irq |->
      state_q == ST_ASLEEP ##1 state_q == ST_WAKING)
      else $error("Wake interrupt outside sleep or sleep not ended");
   dp_low_wake_a: assert property ($rose(asleep) && dp_low_q |=>
      state_q == ST_WAKING ##1 state_q == ST_AWAKE)
      else $error("D+ low did not end sleep at once");
   se0_drive_a: assert property (tx_en && tx_se0 |=> line_oe && !dp_out && !dm_out)
      else $error("Forced SE0 not driven");
   k_state_a: assert property (tx_en && !tx_se0 && !tx_ls |=> line_oe && !dp_out && dm_out)
      else $error("K state not driven");
   j_state_a: assert property (tx_en && !tx_se0 && tx_ls |=> line_oe && dp_out && !dm_out)
      else $error("J state not driven");
   sie_pass_a: assert property (!tx_en |=> dp_out == $past(sie_drive.dp) &&
      dm_out == $past(sie_drive.dm) && line_oe == ($past(sie_drive.oe) && $past(usb_enable)))
      else $error("SIE drive not passed through");
   bus_off_a: assert property (!usb_enable && !tx_en |=> !line_oe)
      else $error("Pins driven while disabled");
   activity_hold_a: assert property (activity_evt |=> activity_q)
      else $error("Activity flag missed an edge");
   activity_clear_a: assert property (wr_lane0 && idx == IDX_BUS_CTRL &&
      pwdata[ACTIVITY_BIT] && !activity_evt |=> !activity_q)
      else $error("Activity flag not cleared by firmware");
   reg_mode_a: assert property (wr_lane0 && idx == IDX_BUS_CTRL |=>
      regulator_mode == $past(pwdata[REG_MODE_BIT]))
      else $error("Regulator mode write lost");
   addr_write_a: assert property (wr_lane0 && idx == IDX_ADDR_EN && !bus_reset |=>
      addr_en_q == $past(pwdata[7:0]))
      else $error("Address write lost");
   frame_load_a: assert property (sof_in.valid && usb_enable && state_q == ST_AWAKE |=>
      frame_q == $past(sof_in.number))
      else $error("Frame number not loaded");
   frame_ro_a: assert property (wr_en && (idx == IDX_FRAME_LO || idx == IDX_FRAME_HI) &&
      !sof_in.valid && !nonretained_clear |=> $stable(frame_q))
      else $error("Frame number changed by a write");
   frame_hold_a: assert property (state_q == ST_ASLEEP |=> $stable(frame_q))
      else $error("Frame number changed in sleep");
   nonret_clear_a: assert property (nonretained_clear |=> frame_q == FRAME_RESET &&
      state_q == ST_AWAKE)
      else $error("Frame number kept after deep wake");
   nonret_mode_a: assert property (nonretained_clear |-> mode_q != SLEEP_RETAIN)
      else $error("Retention wake cleared registers");
   sleep_enter_a: assert property (sleep_req && state_q == ST_AWAKE |=> asleep)
      else $error("Sleep request not taken");
   retain_a: assert property (state_q == ST_ASLEEP && !bus_reset |=>
      $stable(addr_en_q) && $stable(manual_q) && $stable(bus_ctrl_q))
      else $error("Retained register changed in sleep");
   match_enable_a: assert property (addr_match |-> addr_en_q[ENABLE_BIT])
      else $error("Address match while disabled");
   rx_read_a: assert property (rd_en && idx == IDX_MANUAL_TX |->
      prdata[RX_DIFF_BIT] == (dp_s && !dm_s))
      else $error("Receiver bit wrong");

   // Main scenarios
   resume_c: cover property (tx_en && tx_ls ##1 tx_en && !tx_ls [*3] ##1 !tx_en);
   deep_wake_c: cover property (asleep && mode_q == SLEEP_DEEP ##1 nonretained_clear);
   reset_c: cover property (usb_enable ##1 bus_reset ##1 !usb_enable);
   dp_low_c: cover property ($rose(asleep) && dp_low_q);
   sof_load_c: cover property (sof_in.valid && usb_enable && state_q == ST_AWAKE);
endmodule

// ===== rtl/usb_ctrl_pkg.sv
// Package of register map, field layout and types for the USB bus control block
package usb_ctrl_pkg;
   // ------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [7:0] IDX_FRAME_LO = 8'h31;
   localparam logic [7:0] IDX_FRAME_HI = 8'h32;
   localparam logic [7:0] IDX_ADDR_EN = 8'h33;
   localparam logic [7:0] IDX_MANUAL_TX = 8'h34;
   localparam logic [7:0] IDX_BUS_CTRL = 8'h40;
   localparam logic [7:0] IDX_SLEEP_CTRL = 8'h41;
   localparam int ADDR_LSB = 2;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int ENABLE_BIT = 7;
   localparam int ADDR_MSB = 6;
   localparam int TX_EN_BIT = 7;
   localparam int TX_SE0_BIT = 6;
   localparam int TX_LS_BIT = 5;
   localparam int RX_DIFF_BIT = 0;
   localparam int REG_MODE_BIT = 0;
   localparam int OSC_LOCK_BIT = 1;
   localparam int ACTIVITY_BIT = 2;
   localparam int SLEEP_REQ_BIT = 7;
   localparam int FRAME_W = 11;
   localparam int FRAME_LO_W = 8;
   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_EN_RESET = 8'h00;
   localparam logic [2:0] MANUAL_TX_RESET = 3'h0;
   localparam logic [1:0] BUS_CTRL_RESET = 2'h0;
   localparam logic [10:0] FRAME_RESET = 11'h000;
   // Idle J level of the lines, used as the synchroniser reset value
   localparam logic DP_IDLE = 1'b1;
   localparam logic DM_IDLE = 1'b0;
   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      SLEEP_RETAIN = 2'b00,
      SLEEP_STANDBY = 2'b01,
      SLEEP_DEEP = 2'b10
   } sleep_mode_type;
   typedef enum logic [1:0] {
      ST_AWAKE = 2'b00,
      ST_ASLEEP = 2'b01,
      ST_WAKING = 2'b10
   } sleep_state_type;
   typedef struct packed {
      logic dp;
      logic dm;
      logic oe;
   } line_drive_type;
   typedef struct packed {
      logic valid;
      logic [10:0] number;
   } sof_type;
endpackage

// ===== verif/tb_top.sv
// Self-checking bench for the USB bus control block
`timescale 1ns/1ps
module tb_top;
   import usb_ctrl_pkg::*;
   // ------------------------------------------------------------
   // Signals and case tables
   // ------------------------------------------------------------
   typedef struct {logic [7:0] idx; logic [7:0] wd; logic [7:0] rd; logic err;} row_type;
   typedef struct {logic [7:0] code; logic [2:0] pins;} tx_type;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [3:0] pstrb = 4'hf;
   logic [31:0] prdata, rdata;
   logic pready, pslverr, dp_in, dm_in, dp_out, dm_out, line_oe, bus_reset, addr_match;
   logic usb_enable, regulator_mode, osc_lock_enable, asleep, wake_irq, nonretained_clear;
   logic er, irq, clr;
   line_drive_type sie_drive = '0;
   sof_type sof_in;
   logic [6:0] token_addr = '0;
   int err_count = 0;
   int cmp_count = 0;
   // Frame registers read back the reset frame because no SOF came yet
   row_type rows [7] = '{'{IDX_ADDR_EN, 8'h85, 8'h85, 1'b0}, '{IDX_ADDR_EN, 8'h7f, 8'h7f, 1'b0},
      '{IDX_BUS_CTRL, 8'h03, 8'h03, 1'b0}, '{IDX_BUS_CTRL, 8'h00, 8'h00, 1'b0},
      '{IDX_FRAME_LO, 8'hff, 8'h00, 1'b0}, '{IDX_FRAME_HI, 8'hff, 8'h00, 1'b0},
      '{8'h3f, 8'h12, 8'h00, 1'b1}};
   // Resume order first: J, K, then forced SE0 cases, then back to the SIE
   tx_type txs [5] = '{'{8'ha0, 3'b101}, '{8'h80, 3'b011}, '{8'hc0, 3'b001},
      '{8'he0, 3'b001}, '{8'h00, 3'b111}};
   always #5 pclk = ~pclk;
   usb_bus_control usb_bus_control_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .dp_in(dp_in), .dm_in(dm_in),
      .dp_out(dp_out), .dm_out(dm_out), .line_oe(line_oe), .sie_drive(sie_drive),
      .sof_in(sof_in), .bus_reset(bus_reset), .token_addr(token_addr),
      .addr_match(addr_match), .usb_enable(usb_enable), .regulator_mode(regulator_mode),
      .osc_lock_enable(osc_lock_enable), .asleep(asleep), .wake_irq(wake_irq),
      .nonretained_clear(nonretained_clear));
   usb_host_model usb_host_model_i (.pclk(pclk), .dp_out(dp_out), .dm_out(dm_out),
      .line_oe(line_oe), .dp_in(dp_in), .dm_in(dm_in), .sof_in(sof_in),
      .bus_reset(bus_reset));
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Waits on pready with no assumed latency; only the watchdog ends a hang
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {22'h0, idx, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdata = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 8'h00);
      check(rdata, exp);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask
   // First look lands in the cycle right after the launching edge
   task automatic wait_wake();
      irq = 1'b0;
      clr = 1'b0;
      repeat (20) begin
         #1;
         irq = irq | wake_irq;
         clr = clr | nonretained_clear;
         @(posedge pclk);
      end
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge pclk);
      err_count++;
      results();
   end
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      tick(1);
      check(32'({asleep, line_oe, usb_enable, regulator_mode, osc_lock_enable}), 0);
      rdc(IDX_ADDR_EN, 32'h0);
      apb(1'b1, IDX_BUS_CTRL, 8'h04);
      foreach (rows[i]) begin
         apb(1'b1, rows[i].idx, rows[i].wd);
         rdc(rows[i].idx, 32'(rows[i].rd));
         check(32'(er), 32'(rows[i].err));
      end
      $display("table test done");
      pstrb <= 4'h0;
      apb(1'b1, IDX_ADDR_EN, 8'haa);
      pstrb <= 4'hf;
      rdc(IDX_ADDR_EN, 32'h7f);
      apb(1'b1, IDX_ADDR_EN, 8'h85);
      token_addr <= 7'h05;
      tick(1);
      check(32'(addr_match), 1);
      @(posedge pclk);
      token_addr <= 7'h06;
      tick(1);
      check(32'(addr_match), 0);
      apb(1'b1, IDX_ADDR_EN, 8'h05);
      token_addr <= 7'h05;
      tick(1);
      check(32'(addr_match), 0);
      apb(1'b1, IDX_ADDR_EN, 8'h85);
      usb_host_model_i.reset_bus();
      rdc(IDX_ADDR_EN, 32'h0);
      $display("address test done");
      apb(1'b1, IDX_ADDR_EN, 8'h80);
      sie_drive <= 3'b111;
      foreach (txs[i]) begin
         apb(1'b1, IDX_MANUAL_TX, txs[i].code);
         tick(4);
         check(32'({dp_out, dm_out, line_oe}), 32'(txs[i].pins));
         rdc(IDX_MANUAL_TX, 32'(txs[i].code | (txs[i].pins[2] & !txs[i].pins[1])));
      end
      sie_drive <= '0;
      $display("manual transmit test done");
      usb_host_model_i.sof(11'h5a3);
      rdc(IDX_FRAME_LO, 32'ha3);
      rdc(IDX_FRAME_HI, 32'h05);
      apb(1'b1, IDX_ADDR_EN, 8'h00);
      usb_host_model_i.sof(11'h1ff);
      rdc(IDX_FRAME_LO, 32'ha3);
      apb(1'b1, IDX_ADDR_EN, 8'h80);
      $display("frame test done");
      // Firmware polls and clears the flag
      apb(1'b1, IDX_BUS_CTRL, 8'h04);
      rdc(IDX_BUS_CTRL, 32'h0);
      usb_host_model_i.lines(1'b0, 1'b1);
      usb_host_model_i.lines(1'b1, 1'b0);
      tick(4);
      rdc(IDX_BUS_CTRL, 32'h4);
      rdc(IDX_BUS_CTRL, 32'h4);
      apb(1'b1, IDX_BUS_CTRL, 8'h05);
      rdc(IDX_BUS_CTRL, 32'h1);
      $display("activity test done");
      check(32'(wake_irq), 0);
      for (int m = 0; m < 3; m++) begin
         usb_host_model_i.sof(11'h5a3);
         apb(1'b1, IDX_SLEEP_CTRL, 8'h80 | 8'(m));
         tick(2);
         check(32'(asleep), 1);
         usb_host_model_i.lines(1'b0, 1'b1);
         wait_wake();
         check(32'({irq, clr, asleep}), 32'({1'b1, m != 0, 1'b0}));
         rdc(IDX_FRAME_LO, (m == 0) ? 32'ha3 : 32'h0);
         rdc(IDX_ADDR_EN, 32'h80);
         apb(1'b0, IDX_BUS_CTRL, 8'h00);
         check(rdata & 32'h3, 32'h1);
         if (m != 0) apb(1'b1, IDX_ADDR_EN, 8'h80);
         usb_host_model_i.lines(1'b1, 1'b0);
         tick(4);
      end
      usb_host_model_i.lines(1'b0, 1'b1);
      tick(4);
      apb(1'b1, IDX_SLEEP_CTRL, 8'h81);
      wait_wake();
      check(32'({irq, asleep}), 32'h2);
      $display("sleep test done");
      // Reset in mid-run: everything falls back to passthrough and tristate
      apb(1'b1, IDX_BUS_CTRL, 8'h03);
      presetn <= 1'b0;
      tick(2);
      check(32'({regulator_mode, osc_lock_enable, line_oe}), 32'h0);
      @(posedge pclk);
      presetn <= 1'b1;
      tick(1);
      check(32'({asleep, usb_enable, regulator_mode, line_oe}), 32'h0);
      rdc(IDX_FRAME_LO, 32'h0);
      $display("reset test done");
      results();
   end
endmodule

// ===== verif/usb_host_model.sv
// Host side of the full-speed bus: line levels, frame markers and bus reset
`timescale 1ns/1ps
module usb_host_model
   import usb_ctrl_pkg::*;
(
   input wire logic pclk,
   input wire logic dp_out,
   input wire logic dm_out,
   input wire logic line_oe,
   output logic dp_in,
   output logic dm_in,
   output sof_type sof_in,
   output logic bus_reset
);
   // ------------------------------------------------------------
   // Line levels
   // ------------------------------------------------------------
   // Host idles in J; the device wins the wire while its enable is high
   logic hdp = 1'b1;
   logic hdm = 1'b0;
   assign dp_in = line_oe ? dp_out : hdp;
   assign dm_in = line_oe ? dm_out : hdm;
   initial begin
      sof_in = '0;
      bus_reset = 1'b0;
   end
   task automatic lines(input logic dp, input logic dm);
      @(posedge pclk);
      hdp <= dp;
      hdm <= dm;
   endtask
   // ------------------------------------------------------------
   // Decoded host events, one cycle each
   // ------------------------------------------------------------
   task automatic sof(input logic [10:0] num);
      @(posedge pclk);
      sof_in <= {1'b1, num};
      @(posedge pclk);
      sof_in <= '0;
   endtask
   task automatic reset_bus();
      @(posedge pclk);
      bus_reset <= 1'b1;
      @(posedge pclk);
      bus_reset <= 1'b0;
   endtask
endmodule
